/* File: src/clock_gen_pkg.sv */
// constants, codes and types shared by the clock generator control logic
package clock_gen_pkg;

	// register indices as seen by a block transfer
	localparam logic [7:0] IDX_OUT_EN = 8'h00;
	localparam logic [7:0] IDX_SPREAD = 8'h01;
	localparam logic [7:0] IDX_EDGE = 8'h02;
	localparam logic [7:0] IDX_XCOPY = 8'h03;
	localparam logic [7:0] IDX_RSVD4 = 8'h04;
	localparam logic [7:0] IDX_REV_VEND = 8'h05;
	localparam logic [7:0] IDX_DEV_TYPE = 8'h06;
	localparam logic [7:0] IDX_COUNT = 8'h07;

	// field positions in spread_and_amplitude_control
	localparam int SPR_SW_SEL = 5;
	localparam int SPR_SW_HI = 4;
	localparam int SPR_SW_LO = 3;
	localparam int SPR_AMP_HI = 1;
	localparam int SPR_AMP_LO = 0;

	// field positions in crystal_copy_output_control
	localparam int XC_EDGE_HI = 7;
	localparam int XC_EDGE_LO = 6;
	localparam int XC_WOL = 5;
	localparam int XC_EN = 4;

	// field position of readback_count in readback_byte_count
	localparam int CNT_HI = 4;

	// reset values and fixed reserved contents
	localparam logic [7:0] RST_OUT_EN = 8'hFF;
	localparam logic RST_SW_SEL = 1'b0;
	localparam logic [1:0] RST_SW_SPREAD = 2'h0;
	localparam logic [1:0] RST_AMP = 2'h2;
	localparam logic [7:0] RST_EDGE = 8'hFF;
	localparam logic [1:0] RST_XC_EDGE = 2'h1;
	localparam logic RST_XC_WOL = 1'b0;
	localparam logic RST_XC_EN = 1'b1;
	localparam logic [4:0] RST_COUNT = 5'h08;
	localparam logic RSVD_SPREAD_BIT = 1'b1;
	localparam logic [3:0] RSVD_XCOPY_LOW = 4'hF;
	localparam logic [2:0] RSVD_COUNT_HIGH = 3'h0;
	localparam logic [7:0] RSVD_IDX4 = 8'h00;

	// bits per serial byte
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// spread amount codes; strap codes share the same encoding
	typedef logic [1:0] spread_code_t;
	localparam spread_code_t SPREAD_OFF = 2'h0;
	localparam spread_code_t SPREAD_QUARTER = 2'h1;
	localparam spread_code_t SPREAD_RESERVED = 2'h2;
	localparam spread_code_t SPREAD_HALF = 2'h3;

	// serial slave phases
	typedef enum logic [3:0] {
		SMB_IDLE, SMB_ADDR, SMB_ADDR_ACK, SMB_INDEX, SMB_INDEX_ACK, SMB_COUNT, SMB_COUNT_ACK,
		SMB_WDATA, SMB_WDATA_ACK, SMB_TX, SMB_TX_ACK
	} smb_phase_t;

endpackage

/* File: src/line_event_if.sv */
// line events passed from the serial line watcher to the control core
interface line_event_if;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic sda_level;

	modport watch (output scl_rise, output scl_fall, output start_seen, output stop_seen,
		output sda_level);
	modport core (input scl_rise, input scl_fall, input start_seen, input stop_seen,
		input sda_level);
endinterface

/* File: src/smbus_line_watch.sv */
// serial clock and data edge, start and stop detection
module smbus_line_watch (
	input logic ref_clk,
	input logic sys_rst,
	input logic scl_in,
	input logic sda_in,
	line_event_if.watch ev
);
	import clock_gen_pkg::*;

	typedef struct packed {
		logic scl_q;
		logic sda_q;
		logic scl_rise;
		logic scl_fall;
		logic start_seen;
		logic stop_seen;
		logic sda_level;
	} watch_state_t;

	localparam watch_state_t WATCH_RST = '{scl_q: 1'b1, sda_q: 1'b1, sda_level: 1'b1,
		default: 1'b0};

	watch_state_t w_r;
	watch_state_t w_nxt;

	// edges of the clock line, start and stop from data moving while clock is high
	always_comb
	begin
		w_nxt = w_r;
		w_nxt.scl_q = scl_in;
		w_nxt.sda_q = sda_in;
		w_nxt.sda_level = sda_in;
		w_nxt.scl_rise = !w_r.scl_q && scl_in;
		w_nxt.scl_fall = w_r.scl_q && !scl_in;
		w_nxt.start_seen = w_r.scl_q && scl_in && w_r.sda_q && !sda_in;
		w_nxt.stop_seen = w_r.scl_q && scl_in && !w_r.sda_q && sda_in;
	end

	// state register
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			w_r <= WATCH_RST;
		else
			w_r <= w_nxt;
	end

	// events leave straight from flip-flops
	assign ev.scl_rise = w_r.scl_rise;
	assign ev.scl_fall = w_r.scl_fall;
	assign ev.start_seen = w_r.start_seen;
	assign ev.stop_seen = w_r.stop_seen;
	assign ev.sda_level = w_r.sda_level;
endmodule // smbus_line_watch

/* File: src/clock_gen_ctrl.sv */
// control and status register bank of the clock generator behind its serial port

module clock_gen_ctrl #(
	parameter logic [6:0] BUS_ADDR_SEL0 = 7'h50,
	parameter logic [6:0] BUS_ADDR_SEL1 = 7'h52,
	parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
	parameter logic [3:0] VENDOR_CODE = 4'h5, // arbitrary value
	parameter logic [1:0] DEVICE_TYPE_CODE = 2'h2, // arbitrary value
	parameter logic [5:0] DEVICE_CODE = 6'h15 // arbitrary value
)(
	input logic ref_clk,
	input logic sys_rst,
	input logic scl_in,
	input logic sda_in,
	output logic sda_out,
	output logic sda_drive_n,
	input logic power_good_down_pin,
	input logic addr_select_pin,
	input clock_gen_pkg::spread_code_t spread_strap_level,
	input logic [7:0] pair_enable_pin_n,
	output logic [7:0] hcsl_pair_run,
	output logic [7:0] per_output_edge_rate_select,
	output logic [1:0] hcsl_amplitude,
	output clock_gen_pkg::spread_code_t spread_mode,
	output logic [1:0] xtal_copy_edge_rate,
	output logic xtal_copy_run,
	output logic xtal_copy_drive_n
);
	import clock_gen_pkg::*;

	// the two selectable bus addresses must differ
	generate
		if (BUS_ADDR_SEL0 == BUS_ADDR_SEL1)
		begin : g_addr_check
			$error("bus addresses for the two select levels must differ");
		end
	endgenerate

	typedef struct packed {
		smb_phase_t phase;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] index;
		logic is_read;
		logic host_acked;
		logic strap_taken;
		spread_code_t strap;
		logic addr_sel;
		logic [7:0] out_en;
		logic sw_sel;
		spread_code_t sw_spread;
		logic [1:0] amp;
		logic [7:0] edge_fast;
		logic [1:0] xc_edge;
		logic xc_wol;
		logic xc_en;
		logic [4:0] count;
		logic sda_out;
		logic sda_drive_n;
		logic [7:0] pair_run;
		logic [7:0] pair_fast;
		logic [1:0] amp_out;
		spread_code_t spread_out;
		logic [1:0] xc_edge_out;
		logic xc_run;
		logic xc_drive_n;
	} ctrl_state_t;

	localparam ctrl_state_t CTRL_RST = '{
		phase: SMB_IDLE,
		bit_cnt: 4'h0,
		shift: 8'h00,
		index: 8'h00,
		is_read: 1'b0,
		host_acked: 1'b0,
		strap_taken: 1'b0,
		strap: SPREAD_OFF,
		addr_sel: 1'b0,
		out_en: RST_OUT_EN,
		sw_sel: RST_SW_SEL,
		sw_spread: RST_SW_SPREAD,
		amp: RST_AMP,
		edge_fast: RST_EDGE,
		xc_edge: RST_XC_EDGE,
		xc_wol: RST_XC_WOL,
		xc_en: RST_XC_EN,
		count: RST_COUNT,
		sda_out: 1'b0,
		sda_drive_n: 1'b1,
		pair_run: 8'h00,
		pair_fast: RST_EDGE,
		amp_out: RST_AMP,
		spread_out: SPREAD_OFF,
		xc_edge_out: RST_XC_EDGE,
		xc_run: 1'b0,
		xc_drive_n: 1'b1
	};

	ctrl_state_t s_r;
	ctrl_state_t s_nxt;
	line_event_if ev ();

	// line watcher turns pin samples into one-cycle events
	smbus_line_watch u_watch (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.ev(ev.watch)
	);

	// read decode, shared by the first data byte and each following one
	function automatic logic [7:0] read_byte(input ctrl_state_t st, input logic [7:0] idx);
		logic [7:0] d;
		d = 8'h00;
		case (idx)
			IDX_OUT_EN: d = st.out_en;
			IDX_SPREAD: d = {st.strap, st.sw_sel, st.sw_spread, RSVD_SPREAD_BIT, st.amp};
			IDX_EDGE: d = st.edge_fast;
			IDX_XCOPY: d = {st.xc_edge, st.xc_wol, st.xc_en, RSVD_XCOPY_LOW};
			IDX_RSVD4: d = RSVD_IDX4;
			IDX_REV_VEND: d = {REVISION_CODE, VENDOR_CODE};
			IDX_DEV_TYPE: d = {DEVICE_TYPE_CODE, DEVICE_CODE};
			IDX_COUNT: d = {RSVD_COUNT_HIGH, st.count};
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	// address matched against the level latched with the strap
	function automatic logic addr_hit(input ctrl_state_t st);
		logic [6:0] mine;
		mine = st.addr_sel ? BUS_ADDR_SEL1 : BUS_ADDR_SEL0;
		return st.shift[7:1] == mine;
	endfunction

	// next-state logic
	always_comb
	begin
		s_nxt = s_r;

		// strap and address select caught once, at the first power-good
		if (!s_r.strap_taken && power_good_down_pin)
		begin
			s_nxt.strap_taken = 1'b1;
			s_nxt.strap = spread_strap_level;
			s_nxt.addr_sel = addr_select_pin;
		end

		// shift in data on clock rise in every receiving phase
		if (ev.scl_rise)
		begin
			case (s_r.phase)
				SMB_ADDR, SMB_INDEX, SMB_COUNT, SMB_WDATA:
				begin
					s_nxt.shift = {s_r.shift[6:0], ev.sda_level};
					s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
				end
				SMB_TX_ACK:
					s_nxt.host_acked = !ev.sda_level;
				default:
				begin
				end
			endcase
		end

		// advance on clock fall, when the data line may change
		if (ev.scl_fall)
		begin
			case (s_r.phase)
				SMB_ADDR:
				begin
					if (s_r.bit_cnt == BYTE_BITS)
					begin
						if (addr_hit(s_r))
						begin
							s_nxt.phase = SMB_ADDR_ACK;
							s_nxt.is_read = s_r.shift[0];
							s_nxt.sda_drive_n = 1'b0;
						end
						else
							s_nxt.phase = SMB_IDLE;
					end
				end
				SMB_INDEX, SMB_COUNT, SMB_WDATA:
				begin
					if (s_r.bit_cnt == BYTE_BITS)
					begin
						s_nxt.sda_drive_n = 1'b0;
						if (s_r.phase == SMB_INDEX)
						begin
							s_nxt.index = s_r.shift;
							s_nxt.phase = SMB_INDEX_ACK;
						end
						else if (s_r.phase == SMB_COUNT)
							s_nxt.phase = SMB_COUNT_ACK;
						else
						begin
							s_nxt.phase = SMB_WDATA_ACK;
							s_nxt.index = s_r.index + 8'h01;
							// stores; read-only and reserved bits keep their values
							case (s_r.index)
								IDX_OUT_EN: s_nxt.out_en = s_r.shift;
								IDX_SPREAD:
								begin
									s_nxt.sw_sel = s_r.shift[SPR_SW_SEL];
									s_nxt.sw_spread = s_r.shift[SPR_SW_HI:SPR_SW_LO];
									s_nxt.amp = s_r.shift[SPR_AMP_HI:SPR_AMP_LO];
								end
								IDX_EDGE: s_nxt.edge_fast = s_r.shift;
								IDX_XCOPY:
								begin
									s_nxt.xc_edge = s_r.shift[XC_EDGE_HI:XC_EDGE_LO];
									s_nxt.xc_wol = s_r.shift[XC_WOL];
									s_nxt.xc_en = s_r.shift[XC_EN];
								end
								IDX_COUNT: s_nxt.count = s_r.shift[CNT_HI:0];
								default:
								begin
								end
							endcase
						end
					end
				end
				SMB_ADDR_ACK:
				begin
					s_nxt.bit_cnt = 4'h0;
					if (s_r.is_read)
					begin
						// read opens with the count, then data from the index
						s_nxt.phase = SMB_TX;
						s_nxt.shift = {RSVD_COUNT_HIGH, s_r.count};
						// the count's top bit is a reserved zero, so the line is pulled low
						s_nxt.sda_drive_n = RSVD_COUNT_HIGH[2];
					end
					else
					begin
						s_nxt.phase = SMB_INDEX;
						s_nxt.sda_drive_n = 1'b1;
					end
				end
				SMB_INDEX_ACK:
				begin
					s_nxt.phase = SMB_COUNT;
					s_nxt.bit_cnt = 4'h0;
					s_nxt.sda_drive_n = 1'b1;
				end
				SMB_COUNT_ACK, SMB_WDATA_ACK:
				begin
					s_nxt.phase = SMB_WDATA; // byte count ignored; stop ends the write
					s_nxt.bit_cnt = 4'h0;
					s_nxt.sda_drive_n = 1'b1;
				end
				SMB_TX:
				begin
					if (s_r.bit_cnt == BYTE_BITS - 4'h1)
					begin
						s_nxt.phase = SMB_TX_ACK;
						s_nxt.sda_drive_n = 1'b1;
						s_nxt.host_acked = 1'b0;
					end
					else
					begin
						s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
						s_nxt.shift = {s_r.shift[6:0], 1'b0};
						s_nxt.sda_drive_n = s_r.shift[6];
					end
				end
				SMB_TX_ACK:
				begin
					if (s_r.host_acked)
					begin
						// next sequential byte
						s_nxt.phase = SMB_TX;
						s_nxt.bit_cnt = 4'h0;
						s_nxt.shift = read_byte(s_r, s_r.index);
						s_nxt.sda_drive_n = s_nxt.shift[7]; // msb goes out first
						s_nxt.index = s_r.index + 8'h01;
					end
					else
						s_nxt.phase = SMB_IDLE;
				end
				default:
				begin
				end
			endcase
		end

		// start or repeated start restarts addressing; stop releases the line
		if (ev.start_seen)
		begin
			s_nxt.phase = SMB_ADDR;
			s_nxt.bit_cnt = 4'h0;
			s_nxt.sda_drive_n = 1'b1;
		end
		else if (ev.stop_seen)
		begin
			s_nxt.phase = SMB_IDLE;
			s_nxt.sda_drive_n = 1'b1;
		end

		// pair gating: power good, software enable and enable pin all needed
		for (int i = 0; i < 8; i++)
			s_nxt.pair_run[i] = power_good_down_pin && s_r.out_en[i] && !pair_enable_pin_n[i];

		// analog settings follow the register fields
		s_nxt.pair_fast = s_r.edge_fast;
		s_nxt.amp_out = s_r.amp;
		s_nxt.spread_out = s_r.sw_sel ? s_r.sw_spread : s_r.strap;
		s_nxt.xc_edge_out = s_r.xc_edge;
		s_nxt.xc_run = s_r.xc_en && (power_good_down_pin || s_r.xc_wol);
		s_nxt.xc_drive_n = !s_r.strap_taken; // floats until the first power-good
		s_nxt.sda_out = 1'b0; // open-drain: only ever pulls low
	end

	// state register
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_r <= CTRL_RST;
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign sda_out = s_r.sda_out;
	assign sda_drive_n = s_r.sda_drive_n;
	assign hcsl_pair_run = s_r.pair_run;
	assign per_output_edge_rate_select = s_r.pair_fast;
	assign hcsl_amplitude = s_r.amp_out;
	assign spread_mode = s_r.spread_out;
	assign xtal_copy_edge_rate = s_r.xc_edge_out;
	assign xtal_copy_run = s_r.xc_run;
	assign xtal_copy_drive_n = s_r.xc_drive_n;
endmodule // clock_gen_ctrl

/* File: bench/clock_gen_ctrl_props.sv */
// port assertions of the clock generator control registers
module clock_gen_ctrl_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_drive_n,
	input wire logic power_good_down_pin,
	input wire logic [7:0] pair_enable_pin_n,
	input wire logic [7:0] hcsl_pair_run,
	input wire logic [7:0] per_output_edge_rate_select,
	input wire logic [1:0] hcsl_amplitude,
	input wire clock_gen_pkg::spread_code_t spread_mode,
	input wire logic [1:0] xtal_copy_edge_rate,
	input wire logic xtal_copy_drive_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import clock_gen_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic seen_pg_r;
	// remembers the first power-good since reset
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			seen_pg_r <= 1'b0;
		else
			seen_pg_r <= seen_pg_r | power_good_down_pin;
	a_pair_pin_gate: assert property ($stable(pair_enable_pin_n)
		|-> (hcsl_pair_run & pair_enable_pin_n) == 8'h00) else $error("pair runs with pin off");
	a_pairs_power_down: assert property (!power_good_down_pin && !$past(power_good_down_pin)
		|-> hcsl_pair_run == 8'h00) else $error("pair runs in power down");
	a_sda_open_drain: assert property (sda_out == 1'b0) else $error("data driven high");
	a_sda_scl_low: assert property ($changed(sda_drive_n) |-> !scl_in)
		else $error("data moved while clock high");
	a_ack_release: assert property ($fell(sda_drive_n) |-> ##[1:300] sda_drive_n)
		else $error("data line never released");
	a_xcopy_driven: assert property ($past(seen_pg_r, 2) |-> !xtal_copy_drive_n)
		else $error("crystal copy floats after power-good");
	a_spread_held: assert property ($changed(spread_mode) && $past(seen_pg_r, 3)
		|-> !scl_in) else $error("spread moved without bus write");
	a_fields_scl_low: assert property ($changed({per_output_edge_rate_select,
		hcsl_amplitude, xtal_copy_edge_rate}) |-> !scl_in) else $error("field moved off bus");
endmodule // clock_gen_ctrl_props

/* File: bench/smbus_host_model.sv */
// serial host issuing indexed block transfers on the open-drain line
module smbus_host_model #(
	parameter logic [6:0] ADDR = 7'h50
)(
	input wire logic ref_clk,
	input wire logic sda_line,
	output logic scl_pin,
	output logic sda_host
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl_pin = 1'b1;
		sda_host = 1'b1;
	end
	task automatic half();
		repeat (5) @(posedge ref_clk);
	endtask
	// start or repeated start, clock left low
	task automatic start();
		sda_host <= 1'b1;
		half();
		scl_pin <= 1'b1;
		half();
		sda_host <= 1'b0;
		half();
		scl_pin <= 1'b0;
	endtask
	// data moves one cycle after the clock falls, sampled at end of high phase
	task automatic bit_io(input logic b, output logic s);
		@(posedge ref_clk);
		sda_host <= b;
		half();
		scl_pin <= 1'b1;
		half();
		s = sda_line;
		scl_pin <= 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// host acknowledges, or not-acknowledges the last byte
	task automatic get_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
		bit_io(last, s);
	endtask
	task automatic stop();
		@(posedge ref_clk);
		sda_host <= 1'b0;
		half();
		scl_pin <= 1'b1;
		half();
		sda_host <= 1'b1;
		half();
	endtask
	// index, count and data bytes; ok when every byte is acknowledged
	task automatic write_block(input logic [6:0] a, input logic [7:0] idx,
		input logic [7:0] d[$], output logic ok);
		logic k;
		start();
		put_byte({a, 1'b0}, ok);
		put_byte(idx, k);
		ok &= k;
		put_byte(8'(d.size()), k);
		ok &= k;
		foreach (d[i])
		begin
			put_byte(d[i], k);
			ok &= k;
		end
		stop();
	endtask
	// index written, repeated start, count then n bytes
	task automatic read_block(input logic [7:0] idx, input int n,
		output logic [7:0] cnt, output logic [7:0] d[$]);
		logic k;
		logic [7:0] b;
		d = {};
		start();
		put_byte({ADDR, 1'b0}, k);
		put_byte(idx, k);
		start();
		put_byte({ADDR, 1'b1}, k);
		get_byte(1'b0, cnt);
		for (int i = 0; i < n; i++)
		begin
			get_byte(i == n - 1, b);
			d.push_back(b);
		end
		stop();
	endtask
endmodule // smbus_host_model

/* File: bench/testbench.sv */
// self-checking testbench of the clock generator control registers
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import clock_gen_pkg::*;
	logic ref_clk, sys_rst, sda_out, sda_drive_n, power_good_down_pin, addr_select_pin;
	logic scl_pin, sda_host, sda_line, ok, xtal_copy_run, xtal_copy_drive_n;
	logic [7:0] pair_enable_pin_n, hcsl_pair_run, per_output_edge_rate_select, cnt, v;
	logic [1:0] hcsl_amplitude, xtal_copy_edge_rate;
	spread_code_t spread_strap_level, spread_mode;
	logic [7:0] d[$];
	int errors = 0;
	int checks = 0;
	// pulled-up open-drain data line
	assign sda_line = sda_host & (sda_drive_n | sda_out);
	clock_gen_ctrl u_clock_gen_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl_pin),
		.sda_in(sda_line), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
		.power_good_down_pin(power_good_down_pin), .addr_select_pin(addr_select_pin),
		.spread_strap_level(spread_strap_level), .pair_enable_pin_n(pair_enable_pin_n),
		.hcsl_pair_run(hcsl_pair_run), .per_output_edge_rate_select(per_output_edge_rate_select),
		.hcsl_amplitude(hcsl_amplitude), .spread_mode(spread_mode),
		.xtal_copy_edge_rate(xtal_copy_edge_rate), .xtal_copy_run(xtal_copy_run),
		.xtal_copy_drive_n(xtal_copy_drive_n));
	smbus_host_model u_smbus_host_model (.ref_clk(ref_clk), .sda_line(sda_line),
		.scl_pin(scl_pin), .sda_host(sda_host));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] b);
		u_smbus_host_model.write_block(7'h50, idx, {b}, ok);
		check({7'h0, ok}, 8'h01);
	endtask
	task automatic rd(input logic [7:0] idx);
		u_smbus_host_model.read_block(idx, 1, cnt, d);
		v = d[0];
	endtask
	task automatic t_reset_values();
		logic [7:0] e[8];
		e = '{8'hFF, 8'h46, 8'hFF, 8'h5F, 8'h00, 8'h35, 8'h95, 8'h08};
		u_smbus_host_model.read_block(IDX_OUT_EN, 8, cnt, d);
		check(cnt, 8'h08);
		foreach (e[i])
			check(d[i], e[i]);
		check({6'h0, hcsl_amplitude}, 8'h02);
		check({6'h0, spread_mode}, 8'h01);
		check(per_output_edge_rate_select, 8'hFF);
		check({6'h0, xtal_copy_edge_rate}, 8'h01);
		check({6'h0, xtal_copy_run, xtal_copy_drive_n}, 8'h02);
	endtask
	task automatic t_spread();
		wr(IDX_SPREAD, 8'h1B);
		check({6'h0, spread_mode}, 8'h01);
		check({6'h0, hcsl_amplitude}, 8'h03);
		for (int c = 0; c < 4; c++)
		begin
			wr(IDX_SPREAD, {3'h7, 2'(c), 1'b0, 2'(c)});
			check({6'h0, spread_mode}, 8'(c));
			check({6'h0, hcsl_amplitude}, 8'(c));
			rd(IDX_SPREAD);
			check(v, {3'h3, 2'(c), 1'b1, 2'(c)});
		end
	endtask
	task automatic t_strap_held();
		spread_strap_level <= SPREAD_HALF;
		power_good_down_pin <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check(hcsl_pair_run, 8'h00);
		check({7'h0, xtal_copy_run}, 8'h00);
		power_good_down_pin <= 1'b1;
		rd(IDX_SPREAD);
		check({6'h0, v[7:6]}, 8'h01);
	endtask
	task automatic t_edges_block();
		u_smbus_host_model.write_block(7'h50, IDX_EDGE, {8'hA5, 8'h30}, ok);
		check({7'h0, ok}, 8'h01);
		check(per_output_edge_rate_select, 8'hA5);
		check({6'h0, xtal_copy_edge_rate}, 8'h00);
		power_good_down_pin <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check({7'h0, xtal_copy_run}, 8'h01);
		power_good_down_pin <= 1'b1;
		wr(IDX_XCOPY, 8'hC0);
		check({4'h0, xtal_copy_edge_rate, xtal_copy_run, xtal_copy_drive_n}, 8'h0C);
		rd(IDX_XCOPY);
		check(v, 8'hCF);
	endtask
	task automatic t_enables_refused();
		pair_enable_pin_n <= 8'h03;
		wr(IDX_OUT_EN, 8'h0F);
		check(hcsl_pair_run, 8'h0C);
		u_smbus_host_model.write_block(7'h51, IDX_COUNT, {8'h01}, ok);
		check({7'h0, ok}, 8'h00);
		wr(IDX_RSVD4, 8'hFF);
		rd(IDX_RSVD4);
		check(v, 8'h00);
		wr(IDX_COUNT, 8'hFF);
		rd(IDX_COUNT);
		check(cnt, 8'h1F);
		check(v, 8'h1F);
	endtask
	// second power-up: other bus address and a high strap level
	task automatic t_reset_strap();
		sys_rst <= 1'b1;
		power_good_down_pin <= 1'b0;
		addr_select_pin <= 1'b1;
		spread_strap_level <= SPREAD_HALF;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		power_good_down_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check({6'h0, spread_mode}, {6'h0, SPREAD_HALF});
		check(hcsl_pair_run, 8'hFC);
		u_smbus_host_model.write_block(7'h52, IDX_EDGE, {8'h3C}, ok);
		check({7'h0, ok}, 8'h01);
		check(per_output_edge_rate_select, 8'h3C);
		u_smbus_host_model.write_block(7'h50, IDX_EDGE, {8'hFF}, ok);
		check({7'h0, ok}, 8'h00);
		check(per_output_edge_rate_select, 8'h3C);
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// cuts a hung run short
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		errors++;
		conclude();
	end
	initial
	begin
		sys_rst = 1'b1;
		power_good_down_pin = 1'b0;
		addr_select_pin = 1'b0;
		spread_strap_level = SPREAD_QUARTER;
		pair_enable_pin_n = 8'h00;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		power_good_down_pin <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset_values();
		t_spread();
		t_strap_held();
		t_edges_block();
		t_enables_refused();
		t_reset_strap();
		conclude();
	end
endmodule // testbench
bind clock_gen_ctrl clock_gen_ctrl_props u_clock_gen_ctrl_props (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
	.power_good_down_pin(power_good_down_pin), .pair_enable_pin_n(pair_enable_pin_n),
	.hcsl_pair_run(hcsl_pair_run), .per_output_edge_rate_select(per_output_edge_rate_select),
	.hcsl_amplitude(hcsl_amplitude), .spread_mode(spread_mode),
	.xtal_copy_edge_rate(xtal_copy_edge_rate), .xtal_copy_drive_n(xtal_copy_drive_n));
